// *** logic/sps_pkg.sv ***
/*
  Package for the sink power sub-state block: state codes, port-type
  configuration, advertisement ranges and timing constants.
  Assumes a single 250 MHz system clock.
*/
package sps_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS      = 4000;
  localparam int unsigned T_PD_DEBOUNCE_US   = 10;    // least time
  localparam int unsigned T_SINK_ADJ_US      = 60;    // longest time
  localparam int unsigned PD_DEBOUNCE_CYCLES =
    (T_PD_DEBOUNCE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SINK_ADJ_CYCLES    =
    (T_SINK_ADJ_US * 1000000) / CLK_PERIOD_PS;

  // ------------------------------------------------------------------
  // advertised current range seen on cc
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPS_RD_USB = 2'h0,
    SPS_RD_1P5 = 2'h1,
    SPS_RD_3P0 = 2'h2
  } sps_rd_t;

  // cc pin state classification
  typedef enum logic [1:0] {
    SPS_CC_OPEN = 2'h0,
    SPS_CC_RA   = 2'h1,
    SPS_CC_RD   = 2'h2
  } sps_cc_t;

  // current limit codes
  localparam logic [1:0] LIM_DEFAULT = 2'h0;
  localparam logic [1:0] LIM_1P5     = 2'h1;
  localparam logic [1:0] LIM_3P0     = 2'h2;
  localparam logic [1:0] LIM_RESET   = LIM_DEFAULT;

  // ------------------------------------------------------------------
  // connection states, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    SPS_ST_UNATT_SNK  = 6'h01,
    SPS_ST_ATT_SNK    = 6'h02,
    SPS_ST_UNSUP_ACC  = 6'h04,
    SPS_ST_PWR_DEF    = 6'h08,
    SPS_ST_PWR_1P5    = 6'h10,
    SPS_ST_PWR_3P0    = 6'h20
  } sps_state_t;

  // port capabilities, sampled as static straps
  typedef struct packed {
    logic is_source;
    logic is_sink;
    logic try_src;
    logic try_snk;
    logic trywait_snk;
    logic trywait_src;
    logic powered_acc;
    logic unsup_acc;
    logic debug_acc;
    logic unoriented_dbg;
    logic skip_attachwait;
    logic usb2_only_ufp;
    logic pd_capable;
    logic acc_capable;
    logic want_high_current;
  } sps_cfg_t;

  // cc and vbus status inputs
  typedef struct packed {
    sps_cc_t cc1;
    sps_cc_t cc2;
    sps_rd_t rd;
    logic    vbus_present;
    logic    vbus_default;
    logic    pd_contract;
  } sps_sense_t;

endpackage

// *** logic/sps_fsm.sv ***
/*
  Sink power sub-state machine with the unsupported-accessory wait state
  and a port-type configuration check with the protocol gate.
  Assumes cc classification and vbus sense come from an analog front end
  on pins (synchronised here), and configuration straps are static.
*/
`timescale 1ns/10ps

module sps_fsm #(
  parameter int unsigned DEBOUNCE_CYCLES = sps_pkg::PD_DEBOUNCE_CYCLES,
  parameter int unsigned ADJ_CYCLES      = sps_pkg::SINK_ADJ_CYCLES
) (
  input  wire logic               clk_in,          // 250 MHz clock
  input  wire logic               rst_b_in,        // sync reset, low
  input  wire sps_pkg::sps_cfg_t   cfg_in,          // static straps
  input  wire sps_pkg::sps_sense_t sense_in,        // pin sense, async
  input  wire logic               attach_in,       // attach done, same clock
  input  wire logic               unsup_acc_in,    // enter unsupported acc
  output sps_pkg::sps_state_t      state_out,       // current state
  output logic [1:0]              limit_out,       // allowed draw code
  output logic                    adj_busy_out,    // load reduce window
  output logic                    adj_late_out,    // load not reduced in time
  output logic                    rd_monitor_out,  // advertisement watched
  output logic                    cc1_rd_out,      // Rd applied on cc1
  output logic                    cc2_rd_out,      // Rd applied on cc2
  output logic                    vbus_en_out,     // vbus supply enable
  output logic                    vconn_en_out,    // vconn supply enable
  output logic                    pd_allow_out,    // protocol permitted
  output logic                    cfg_error_out,   // illegal strap set
  input  wire logic               load_low_in      // load reached new limit
);
  import sps_pkg::*;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  sps_sense_t sense_meta;
  sps_sense_t sense;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sense_meta <= '0;
      sense      <= '0;
    end else begin
      sense_meta <= sense_in;
      sense      <= sense_meta;
    end
  end

  // ------------------------------------------------------------------
  // configuration straps, registered every cycle after reset
  // ------------------------------------------------------------------
  sps_cfg_t cfg;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_in;
    end
  end

  // ------------------------------------------------------------------
  // configuration legality
  // ------------------------------------------------------------------
  function automatic logic cfg_bad(input sps_cfg_t c);
    logic bad;
    bad = 1'b0;
    if (!c.is_source && !c.is_sink)
      bad = 1'b1;
    if (c.skip_attachwait &&
        (!c.usb2_only_ufp || c.pd_capable || c.acc_capable ||
         c.want_high_current || c.is_source))
      bad = 1'b1;
    if (c.try_src && !c.trywait_snk)
      bad = 1'b1;
    if (c.try_snk && !c.trywait_src)
      bad = 1'b1;
    if (c.powered_acc && !c.unsup_acc)
      bad = 1'b1;
    if (c.try_src && c.try_snk)
      bad = 1'b1;
    if (c.debug_acc && c.is_source && !c.unoriented_dbg)
      bad = 1'b1;
    if ((c.try_src || c.try_snk) && !(c.is_source && c.is_sink))
      bad = 1'b1;
    if ((c.powered_acc || c.unsup_acc) && c.is_source)
      bad = 1'b1;
    return bad;
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cfg_error_out <= 1'b0;
    end else begin
      cfg_error_out <= cfg_bad(cfg);
    end
  end

  // ------------------------------------------------------------------
  // advertisement debounce
  // ------------------------------------------------------------------
  localparam int unsigned DB_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);

  sps_rd_t         rd_seen;
  sps_rd_t         rd_stable;
  logic [DB_W-1:0] db_cnt;

  // restart on every change so a bouncing level never qualifies
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_seen   <= SPS_RD_USB;
      rd_stable <= SPS_RD_USB;
      db_cnt    <= '0;
    end else if (sense.rd != rd_seen) begin
      rd_seen <= sense.rd;
      db_cnt  <= '0;
    end else if (db_cnt == DB_LAST) begin
      rd_stable <= rd_seen;
    end else begin
      db_cnt <= db_cnt + DB_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // connection and sub-state machine
  // ------------------------------------------------------------------
  sps_state_t state;
  sps_state_t next_state;
  logic       in_power;
  logic       leave_power;
  logic       mon_cc_open;
  logic       rd_valid;

  assign in_power    = (state == SPS_ST_PWR_DEF) || (state == SPS_ST_PWR_1P5) ||
                       (state == SPS_ST_PWR_3P0);
  assign leave_power = in_power && (!sense.vbus_present || sense.pd_contract);
  assign mon_cc_open = cc1_rd_out ? (sense.cc1 == SPS_CC_OPEN)
                                  : (sense.cc2 == SPS_CC_OPEN);
  assign rd_valid    = rd_stable != SPS_RD_USB && cfg.want_high_current;

  always_comb begin
    next_state = state;
    case (state)
      SPS_ST_UNATT_SNK: begin
        if (unsup_acc_in && cfg.unsup_acc)
          next_state = SPS_ST_UNSUP_ACC;
        else if (attach_in && sense.vbus_present)
          next_state = SPS_ST_ATT_SNK;
      end
      SPS_ST_UNSUP_ACC: begin
        if (mon_cc_open)
          next_state = SPS_ST_UNATT_SNK;
      end
      SPS_ST_ATT_SNK: begin
        if (!sense.vbus_present)
          next_state = SPS_ST_UNATT_SNK;
        else if (sense.vbus_default && !sense.pd_contract)
          next_state = SPS_ST_PWR_DEF;
      end
      SPS_ST_PWR_DEF: begin
        if (leave_power)
          next_state = sense.vbus_present ? SPS_ST_ATT_SNK : SPS_ST_UNATT_SNK;
        else if (rd_valid && rd_stable == SPS_RD_1P5)
          next_state = SPS_ST_PWR_1P5;
        else if (rd_valid && rd_stable == SPS_RD_3P0)
          next_state = SPS_ST_PWR_3P0;
      end
      SPS_ST_PWR_1P5: begin
        if (leave_power)
          next_state = sense.vbus_present ? SPS_ST_ATT_SNK : SPS_ST_UNATT_SNK;
        else if (rd_stable == SPS_RD_USB)
          next_state = SPS_ST_PWR_DEF;
        else if (rd_stable == SPS_RD_3P0)
          next_state = SPS_ST_PWR_3P0;
      end
      SPS_ST_PWR_3P0: begin
        if (leave_power)
          next_state = sense.vbus_present ? SPS_ST_ATT_SNK : SPS_ST_UNATT_SNK;
        else if (rd_stable == SPS_RD_USB)
          next_state = SPS_ST_PWR_DEF;
        else if (rd_stable == SPS_RD_1P5)
          next_state = SPS_ST_PWR_1P5;
      end
      default: next_state = SPS_ST_UNATT_SNK;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= SPS_ST_UNATT_SNK;
    end else begin
      state <= next_state;
    end
  end

  assign state_out = state;

  // ------------------------------------------------------------------
  // current limit and load reduction window
  // ------------------------------------------------------------------
  localparam int unsigned ADJ_W = $clog2(ADJ_CYCLES + 1);
  localparam logic [ADJ_W-1:0] ADJ_LAST = ADJ_W'(ADJ_CYCLES - 1);

  logic [1:0]       next_limit;
  logic [ADJ_W-1:0] adj_cnt;

  always_comb begin
    case (next_state)
      SPS_ST_PWR_1P5: next_limit = LIM_1P5;
      SPS_ST_PWR_3P0: next_limit = LIM_3P0;
      default:        next_limit = LIM_DEFAULT;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      limit_out <= LIM_RESET;
    end else begin
      limit_out <= next_limit;
    end
  end

  // limit drops at once; the load has the window to follow it
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      adj_busy_out <= 1'b0;
      adj_late_out <= 1'b0;
      adj_cnt      <= '0;
    end else if (next_limit < limit_out) begin
      adj_busy_out <= 1'b1;
      adj_late_out <= 1'b0;
      adj_cnt      <= '0;
    end else if (adj_busy_out) begin
      if (load_low_in) begin
        adj_busy_out <= 1'b0;
      end else if (adj_cnt == ADJ_LAST) begin
        adj_busy_out <= 1'b0;
        adj_late_out <= 1'b1;
      end else begin
        adj_cnt <= adj_cnt + ADJ_W'(1);
      end
    end
  end

  // ------------------------------------------------------------------
  // pin control and protocol gate
  // ------------------------------------------------------------------
  logic next_cc1_rd;

  // orientation latched on entry; only one pin keeps its termination
  assign next_cc1_rd = (sense.cc1 == SPS_CC_RD) || (sense.cc2 != SPS_CC_RD);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cc1_rd_out <= 1'b1;
      cc2_rd_out <= 1'b1;
    end else if (next_state == SPS_ST_UNSUP_ACC && state != SPS_ST_UNSUP_ACC) begin
      cc1_rd_out <= next_cc1_rd;
      cc2_rd_out <= !next_cc1_rd;
    end else if (next_state != SPS_ST_UNSUP_ACC) begin
      cc1_rd_out <= 1'b1;
      cc2_rd_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      vbus_en_out    <= 1'b0;
      vconn_en_out   <= 1'b0;
      pd_allow_out   <= 1'b0;
      rd_monitor_out <= 1'b0;
    end else begin
      vbus_en_out    <= 1'b0;
      vconn_en_out   <= 1'b0;
      pd_allow_out   <= (next_state == SPS_ST_ATT_SNK) ||
                        (next_state == SPS_ST_PWR_DEF) ||
                        (next_state == SPS_ST_PWR_1P5) ||
                        (next_state == SPS_ST_PWR_3P0);
      rd_monitor_out <= (next_state == SPS_ST_PWR_1P5) ||
                        (next_state == SPS_ST_PWR_3P0) ||
                        (next_state == SPS_ST_PWR_DEF && cfg.want_high_current) ||
                        (next_state == SPS_ST_UNSUP_ACC);
    end
  end

endmodule

// *** sim/sps_fsm_asserts.sv ***
/*
  Checker for the sink power sub-state block: sub-state timing, load
  reduction, supply and protocol gating, strap checks.
  Assumes it is bound onto sps_fsm and receives that module's parameters.
*/
`timescale 1ns/10ps
module sps_fsm_asserts import sps_pkg::*; #(
  parameter int unsigned DEBOUNCE_CYCLES = 8,
  parameter int unsigned ADJ_CYCLES      = 16
) (
  input wire logic                clk_in,          // clock
  input wire logic                rst_b_in,        // reset
  input wire sps_pkg::sps_cfg_t   cfg_in,          // straps
  input wire sps_pkg::sps_sense_t sense_in,        // pin sense
  input wire logic                attach_in,       // attach done
  input wire logic                unsup_acc_in,    // accessory wait
  input wire logic                load_low_in,     // load reduced
  input wire sps_pkg::sps_state_t state_out,       // state
  input wire logic [1:0]          limit_out,       // draw code
  input wire logic                adj_busy_out,    // reduce window
  input wire logic                adj_late_out,    // reduce late
  input wire logic                rd_monitor_out,  // monitoring
  input wire logic                cc1_rd_out,      // Rd on cc1
  input wire logic                cc2_rd_out,      // Rd on cc2
  input wire logic                vbus_en_out,     // vbus supply
  input wire logic                vconn_en_out,    // vconn supply
  input wire logic                pd_allow_out,    // protocol gate
  input wire logic                cfg_error_out    // strap error
);
  // ------------------------------------------------------------------
  // helper counters: raw range stability and reduce window length
  // ------------------------------------------------------------------
  sps_rd_t     rd_q;
  int unsigned rd_cnt;
  int unsigned busy_cnt;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_q     <= SPS_RD_USB;
      rd_cnt   <= 0;
      busy_cnt <= 0;
    end else begin
      rd_q     <= sense_in.rd;
      rd_cnt   <= (sense_in.rd != rd_q) ? 0 : rd_cnt + 1;
      busy_cnt <= adj_busy_out ? busy_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_supply_off: assert property (!vbus_en_out && !vconn_en_out)
    else $error("supply enable raised");
  a_unsup_one_rd: assert property (state_out == SPS_ST_UNSUP_ACC |-> cc1_rd_out ^ cc2_rd_out)
    else $error("accessory wait without exactly one Rd pin");
  a_unsup_exit: assert property ((state_out == SPS_ST_UNSUP_ACC &&
      ((cc1_rd_out && sense_in.cc1 == SPS_CC_OPEN) || (cc2_rd_out && sense_in.cc2 == SPS_CC_OPEN)))
      [*3] |-> ##[1:3] state_out == SPS_ST_UNATT_SNK)
    else $error("accessory wait kept after monitored pin opened");
  a_enter_default: assert property (state_out inside {SPS_ST_PWR_1P5, SPS_ST_PWR_3P0} |->
      $past(state_out) inside {SPS_ST_PWR_DEF, SPS_ST_PWR_1P5, SPS_ST_PWR_3P0})
    else $error("sub-state entered without default first");
  a_debounce_hold: assert property ($changed(state_out) &&
      state_out inside {SPS_ST_PWR_DEF, SPS_ST_PWR_1P5, SPS_ST_PWR_3P0} &&
      $past(state_out) inside {SPS_ST_PWR_DEF, SPS_ST_PWR_1P5, SPS_ST_PWR_3P0}
      |-> rd_cnt >= DEBOUNCE_CYCLES)
    else $error("sub-state moved before range settled");
  a_limit_1p5: assert property (state_out == SPS_ST_PWR_1P5 |-> limit_out == LIM_1P5)
    else $error("limit wrong in 1.5 sub-state");
  a_limit_3p0: assert property (state_out == SPS_ST_PWR_3P0 |-> limit_out == LIM_3P0)
    else $error("limit wrong in 3.0 sub-state");
  a_adj_drop: assert property (limit_out < $past(limit_out) &&
      state_out inside {SPS_ST_PWR_DEF, SPS_ST_PWR_1P5} |-> adj_busy_out)
    else $error("no reduce window on drop");
  a_adj_clear: assert property (adj_busy_out && load_low_in |=> !adj_busy_out)
    else $error("reduce window kept after load dropped");
  a_adj_late: assert property ($fell(adj_busy_out) && !$past(load_low_in) |-> adj_late_out)
    else $error("late reduce not flagged");
  a_pd_gate: assert property (pd_allow_out == (state_out inside
      {SPS_ST_ATT_SNK, SPS_ST_PWR_DEF, SPS_ST_PWR_1P5, SPS_ST_PWR_3P0}))
    else $error("protocol gate wrong for state");
  a_try_both: assert property ((cfg_in.try_src && cfg_in.try_snk)[*4] |-> cfg_error_out)
    else $error("both try modes not flagged");

  c_pwr_3p0: cover property (state_out == SPS_ST_PWR_3P0);
  c_unsup: cover property (state_out == SPS_ST_UNSUP_ACC);
  c_late: cover property ($rose(adj_late_out));
endmodule

// *** sim/sps_src_model.sv ***
/*
  Behavioural model of the attached source as the sink's pins see it.
  Assumes the bench sets the mode, advertisement and contract flag.
*/
`timescale 1ns/10ps
module sps_src_model import sps_pkg::*; (
  input  wire logic [1:0]         mode_in,   // 0 open, 1 source, 2 accessory
  input  wire sps_pkg::sps_rd_t   adv_in,    // advertised range
  input  wire logic               pd_in,     // contract made
  output sps_pkg::sps_sense_t     sense_out  // sensed at the sink
);
  // detached: cc open and vbus gone, range falls to the lowest reading
  always_comb begin
    sense_out = '0;
    case (mode_in)
      2'h1: begin
        sense_out.cc1          = SPS_CC_RD;
        sense_out.rd           = adv_in;
        sense_out.vbus_present = 1'b1;
        sense_out.vbus_default = 1'b1;
        sense_out.pd_contract  = pd_in;
      end
      2'h2: sense_out.cc1 = SPS_CC_RD;
      default: ;
    endcase
  end
endmodule

// *** sim/sps_fsm_tb.sv ***
/*
  Self-checking bench for sps_fsm with short timer parameters.
  Assumes the source model drives the sense pins and the checker is bound.
*/
`timescale 1ns/10ps
bind sps_fsm sps_fsm_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .ADJ_CYCLES(ADJ_CYCLES)) u_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg_in), .sense_in(sense_in),
  .attach_in(attach_in), .unsup_acc_in(unsup_acc_in), .load_low_in(load_low_in),
  .state_out(state_out), .limit_out(limit_out), .adj_busy_out(adj_busy_out),
  .adj_late_out(adj_late_out), .rd_monitor_out(rd_monitor_out), .cc1_rd_out(cc1_rd_out),
  .cc2_rd_out(cc2_rd_out), .vbus_en_out(vbus_en_out), .vconn_en_out(vconn_en_out),
  .pd_allow_out(pd_allow_out), .cfg_error_out(cfg_error_out));
module sps_fsm_tb;
  import sps_pkg::*;
  localparam int unsigned D    = 8;
  localparam int unsigned A    = 16;
  localparam sps_cfg_t    GOOD = '{is_sink: 1'b1, unsup_acc: 1'b1, pd_capable: 1'b1,
                                   want_high_current: 1'b1, default: 1'b0};
  logic       clk_in   = 1'b0;
  logic       rst_b_in = 1'b0;
  sps_cfg_t   cfg      = GOOD;
  logic       attach   = 1'b0;
  logic       unsup    = 1'b0;
  logic       load_low = 1'b0;
  logic       pd       = 1'b0;
  logic [1:0] mode     = 2'h0;
  sps_rd_t    adv      = SPS_RD_USB;
  sps_sense_t sense;
  sps_state_t state;
  logic [1:0] limit;
  logic       busy, late, mon, cc1_rd, cc2_rd, vbus_en, vconn_en, pd_allow, cfg_err;
  int         mismatches = 0;
  int         n_checks   = 0;
  int         cycles     = 0;

  sps_fsm #(.DEBOUNCE_CYCLES(D), .ADJ_CYCLES(A)) uut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg), .sense_in(sense),
    .attach_in(attach), .unsup_acc_in(unsup), .state_out(state), .limit_out(limit),
    .adj_busy_out(busy), .adj_late_out(late), .rd_monitor_out(mon), .cc1_rd_out(cc1_rd),
    .cc2_rd_out(cc2_rd), .vbus_en_out(vbus_en), .vconn_en_out(vconn_en),
    .pd_allow_out(pd_allow), .cfg_error_out(cfg_err), .load_low_in(load_low));
  sps_src_model u_src (.mode_in(mode), .adv_in(adv), .pd_in(pd), .sense_out(sense));

  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // shared tasks; outputs are read on the falling edge
  // ------------------------------------------------------------------
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task wait_st(input sps_state_t s, input int n);
    for (int i = 0; i < n && state !== s; i++) @(negedge clk_in);
    chk("state", 8'(state), 8'(s));
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task t_cfg;
    sps_cfg_t c;
    chk("supply", {vbus_en, vconn_en}, 8'h00);
    chk("cc_rd", {cc1_rd, cc2_rd}, 8'h03);
    for (int i = 0; i < 6; i++) begin
      c = GOOD;
      case (i)
        0: c.try_src = 1'b1;
        1: c.try_snk = 1'b1;
        2: {c.powered_acc, c.unsup_acc} = 2'h2;
        3: {c.try_src, c.try_snk, c.trywait_snk, c.trywait_src} = 4'hF;
        4: {c.is_source, c.debug_acc} = 2'h3;
        default: c.skip_attachwait = 1'b1;
      endcase
      @(posedge clk_in) cfg <= c;
      cyc(4);
      chk("cfg_error", cfg_err, 8'h01);
    end
    @(posedge clk_in) cfg <= GOOD;
    cyc(4);
    chk("cfg_error", cfg_err, 8'h00);
    $display("t_cfg done");
  endtask
  task t_attach(input logic want);
    @(posedge clk_in) cfg.want_high_current <= want;
    mode <= 2'h1;
    attach <= 1'b1;
    wait_st(SPS_ST_PWR_DEF, 20);
    @(posedge clk_in) attach <= 1'b0;
    cyc(1);
    chk("pd_allow", pd_allow, 8'h01);
    chk("limit", limit, 8'(LIM_DEFAULT));
    $display("t_attach done");
  endtask
  task t_substates;
    @(posedge clk_in) adv <= SPS_RD_1P5;
    cyc(4);
    @(posedge clk_in) adv <= SPS_RD_USB;
    cyc(D + 8);
    chk("glitch", 8'(state), 8'(SPS_ST_PWR_DEF));
    @(posedge clk_in) adv <= SPS_RD_1P5;
    cyc(D);
    chk("early", 8'(state), 8'(SPS_ST_PWR_DEF));
    wait_st(SPS_ST_PWR_1P5, 12);
    cyc(2);
    chk("monitor", mon, 8'h01);
    @(posedge clk_in) adv <= SPS_RD_3P0;
    wait_st(SPS_ST_PWR_3P0, D + 12);
    chk("limit", limit, 8'(LIM_3P0));
    @(posedge clk_in) adv <= SPS_RD_1P5;
    wait_st(SPS_ST_PWR_1P5, D + 12);
    chk("busy", busy, 8'h01);
    chk("limit", limit, 8'(LIM_1P5));
    @(posedge clk_in) load_low <= 1'b1;
    @(posedge clk_in) load_low <= 1'b0;
    cyc(2);
    chk("busy", {busy, late}, 8'h00);
    @(posedge clk_in) adv <= SPS_RD_USB;
    wait_st(SPS_ST_PWR_DEF, D + 12);
    cyc(A + 4);
    chk("late", late, 8'h01);
    $display("t_substates done");
  endtask
  task t_exit;
    @(posedge clk_in) pd <= 1'b1;
    wait_st(SPS_ST_ATT_SNK, 10);
    @(posedge clk_in) mode <= 2'h0;
    wait_st(SPS_ST_UNATT_SNK, 10);
    chk("pd_allow", pd_allow, 8'h00);
    @(posedge clk_in) pd <= 1'b0;
    $display("t_exit done");
  endtask
  task t_low_want;
    t_attach(1'b0);
    @(posedge clk_in) adv <= SPS_RD_3P0;
    cyc(D + 20);
    chk("stay", 8'(state), 8'(SPS_ST_PWR_DEF));
    chk("monitor", mon, 8'h00);
    @(posedge clk_in) mode <= 2'h0;
    adv <= SPS_RD_USB;
    wait_st(SPS_ST_UNATT_SNK, 10);
    @(posedge clk_in) cfg <= GOOD;
    $display("t_low_want done");
  endtask
  task t_unsup;
    @(posedge clk_in) mode <= 2'h2;
    cyc(4);
    @(posedge clk_in) unsup <= 1'b1;
    wait_st(SPS_ST_UNSUP_ACC, 10);
    @(posedge clk_in) unsup <= 1'b0;
    cyc(10);
    chk("cc_rd", {cc1_rd, cc2_rd, vbus_en, vconn_en, pd_allow}, 8'h10);
    chk("hold", 8'(state), 8'(SPS_ST_UNSUP_ACC));
    @(posedge clk_in) mode <= 2'h0;
    wait_st(SPS_ST_UNATT_SNK, 10);
    chk("cc_rd", {cc1_rd, cc2_rd}, 8'h03);
    $display("t_unsup done");
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    cyc(4);
    t_cfg();
    t_attach(1'b1);
    t_substates();
    t_exit();
    t_low_want();
    t_unsup();
    finish_test();
  end
endmodule
